//--- verilog/regfile_pkg.sv
// Field layout, codes and helpers for the R-bus source selector and renamer.
// Assumes words numbered 0 (most significant) to 15, microword 0 to 31.
package regfile_pkg;
  localparam int WORD_W            = 16;
  localparam int MICRO_W           = 32;
  localparam int TOS_DEPTH         = 4;
  localparam int HOLD_SELECT_FIELD_LO     = 28;
  localparam int HOLD_SELECT_FIELD_HI     = 31;
  localparam int SPECIAL_FIELD_LO  = 23;
  localparam int SPECIAL_FIELD_HI  = 27;
  localparam int STORE_FIELD_LO    = 18;
  localparam int STORE_FIELD_HI    = 22;
  localparam int CIR_INDEX_BIT     = 4;
  localparam int SP1_NAME_LO       = 14;
  localparam int SP1_NAME_HI       = 15;
  localparam int COUNT_FIELD_HI    = 2;

  typedef logic [0:WORD_W-1] word_t;
  typedef logic [0:3]        rsel_t;
  typedef logic [0:4]        field5_t;
  typedef logic [1:0]        name_t;
  typedef logic [2:0]        count_t;

  localparam word_t  WORD_ZERO   = 16'h0000;
  localparam name_t  NAME_RESET  = 2'h0;
  localparam count_t COUNT_RESET = 3'h0;
  localparam count_t COUNT_FULL  = 3'h4;
  localparam name_t  OFFS_FIRST  = 2'h0;
  localparam name_t  OFFS_SECOND = 2'h1;
  localparam name_t  OFFS_THIRD  = 2'h2;
  localparam name_t  OFFS_FOURTH = 2'h3;

  // R-bus source codes
  localparam rsel_t RSEL_CODE_LIMIT  = 4'h0;
  localparam rsel_t RSEL_COUNT       = 4'h1;
  localparam rsel_t RSEL_STACK_LIMIT = 4'h2;
  localparam rsel_t RSEL_MEM_IN_TOS  = 4'h3;
  localparam rsel_t RSEL_PRE_ADDER   = 4'h4;
  localparam rsel_t RSEL_HOLD        = 4'h5;
  localparam rsel_t RSEL_INDEX       = 4'h6;
  localparam rsel_t RSEL_COND_INDEX  = 4'h7;
  localparam rsel_t RSEL_FOURTH      = 4'h8;
  localparam rsel_t RSEL_THIRD       = 4'h9;
  localparam rsel_t RSEL_SECOND      = 4'hA;
  localparam rsel_t RSEL_FIRST       = 4'hB;
  localparam rsel_t RSEL_SCRATCH_ONE = 4'hC;
  localparam rsel_t RSEL_SCRATCH_ZER = 4'hD;
  localparam rsel_t RSEL_RESULT_BUS  = 4'hE;
  localparam rsel_t RSEL_NOP         = 4'hF;

  // Store field codes
  localparam field5_t ST_NOP         = 5'h00;
  localparam field5_t ST_INDEX       = 5'h01;
  localparam field5_t ST_STACK_LIMIT = 5'h02;
  localparam field5_t ST_CODE_LIMIT  = 5'h03;
  localparam field5_t ST_SCRATCH_ZER = 5'h04;
  localparam field5_t ST_SCRATCH_ONE = 5'h05;
  localparam field5_t ST_CODE_BASE   = 5'h06;
  localparam field5_t ST_STACK_LOWER = 5'h07;
  localparam field5_t ST_FIRST       = 5'h08;
  localparam field5_t ST_SECOND      = 5'h09;
  localparam field5_t ST_THIRD       = 5'h0A;
  localparam field5_t ST_FOURTH      = 5'h0B;
  localparam field5_t ST_PUSH        = 5'h0C;
  localparam field5_t ST_BOTTOM      = 5'h0D;
  localparam field5_t ST_BUS         = 5'h10;
  localparam field5_t ST_BUS_SP0     = 5'h11;
  localparam field5_t ST_BUS_SP1     = 5'h12;

  // Special field codes that pop the stack
  localparam field5_t SP_POP         = 5'h17;
  localparam field5_t SP_POP_SET_CC  = 5'h16;

  function automatic logic is_bus_store(input field5_t code);
    return (code == ST_BUS) || (code == ST_BUS_SP0) || (code == ST_BUS_SP1);
  endfunction
endpackage

//--- verilog/tos_if.sv
// Bundle between the selector top, the renamer and the top-of-stack bank.
// Assumes all parties share one clock.
`timescale 1ns/1ps
`default_nettype none
interface tos_if;
  import regfile_pkg::*;
  logic                    push;
  logic                    pop;
  logic                    sel_sp1;
  logic                    sel_count;
  name_t                   rd_offset;
  name_t                   wr_offset;
  name_t                   sp1_low;
  name_t                   name;
  count_t                  count;
  name_t                   rd_code;
  name_t                   wr_code;
  logic                    wr_en;
  word_t                   wr_data;
  word_t                   rd_word;
  logic [0:WORD_W*TOS_DEPTH-1] s_copies;

  modport ctrl (output push, pop, sel_sp1, sel_count, rd_offset, wr_offset, sp1_low,
                output wr_en, wr_data, input name, count, rd_word, s_copies);
  modport renamer (input push, pop, sel_sp1, sel_count, rd_offset, wr_offset, sp1_low,
                   output name, count, rd_code, wr_code);
  modport bank (input wr_en, wr_data, rd_code, wr_code, output rd_word, s_copies);
endinterface
`default_nettype wire

//--- verilog/tos_renamer.sv
// Naming register, stack count and the adders that feed the mappers.
// Assumes push and pop come from the decoded microword of this cycle.
`timescale 1ns/1ps
`default_nettype none
module tos_renamer (
  input wire logic CLOCK,
  input wire logic RST,
  tos_if.renamer   tos
);
  import regfile_pkg::*;

  name_t next_name;
  count_t next_count;

  always_comb begin
    next_name  = tos.name;
    next_count = tos.count;
    if (tos.push && !tos.pop) begin
      next_name  = tos.name - 2'h1;
      next_count = tos.count + 3'h1;
    end else if (tos.pop && !tos.push) begin
      next_name  = tos.name + 2'h1;
      next_count = tos.count - 3'h1;
    end
  end

  // Count runs past four up to seven, then wraps to zero; underflow below zero wraps to seven
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tos.name  <= NAME_RESET;
      tos.count <= COUNT_RESET;
    end else begin
      tos.name  <= next_name;
      tos.count <= next_count;
    end
  end

  // Two-bit sums wrap modulo four by width
  always_comb begin
    tos.rd_code = tos.name + tos.rd_offset + (tos.sel_sp1 ? tos.sp1_low : 2'h0);
    tos.wr_code = tos.name + tos.wr_offset
                + (tos.sel_count ? tos.count[1:0] - 2'h1 : 2'h0);
  end
endmodule // tos_renamer
`default_nettype wire

//--- verilog/tos_bank.sv
// Four top-of-stack words, each held as an R-side and an S-side copy.
// Assumes one write port; the read port serves the R-bus selector.
`timescale 1ns/1ps
`default_nettype none
module tos_bank #(
  parameter int DEPTH = 4
) (
  input wire logic CLOCK,
  input wire logic RST,
  tos_if.bank      tos
);
  import regfile_pkg::*;

  // Mappers and adders are two bits wide, so only four words fit
  if (DEPTH != TOS_DEPTH) begin : g_depth_check
    $error("tos_bank serves exactly four words");
  end

  word_t tos_r_copy [DEPTH];
  word_t tos_s_copy [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
        tos_r_copy[i] <= WORD_ZERO;
        tos_s_copy[i] <= WORD_ZERO;
      end else if (tos.wr_en && tos.wr_code == name_t'(i)) begin
        tos_r_copy[i] <= tos.wr_data;
        tos_s_copy[i] <= tos.wr_data;
      end
    end
    assign tos.s_copies[i*WORD_W +: WORD_W] = tos_s_copy[i];
  end

  assign tos.rd_word = tos_r_copy[tos.rd_code];
endmodule // tos_bank
`default_nettype wire

//--- verilog/hold_select_source_select.sv
// R-bus source selector with the processor registers it reads and loads.
// Assumes the sequencer presents one microword per CLOCK and U_BUS on the same clock.
`timescale 1ns/1ps
`default_nettype none
module hold_select_source_select (
  input  wire logic                CLOCK,
  input  wire logic                RST,
  input  wire logic [0:31]         MICRO_WORD,
  input  wire regfile_pkg::word_t  RESULT_BUS,
  input  wire regfile_pkg::word_t  PRE_ADDER_WORD,
  input  wire regfile_pkg::word_t  CURRENT_INSTRUCTION_REG,
  input  wire logic                SCRATCH_ONE_SHIFT,
  input  wire logic                SCRATCH_ONE_SERIAL_IN,
  output regfile_pkg::word_t       R_BUS_REG,
  output regfile_pkg::word_t       SCRATCH_ONE_S,
  output logic                     SCRATCH_ONE_SERIAL_OUT,
  output regfile_pkg::word_t       CODE_SEGMENT_BASE,
  output regfile_pkg::word_t       STACK_LOWER_BOUND,
  output logic [0:63]              TOS_S_COPIES,
  output regfile_pkg::count_t      STACK_ELEMENT_COUNT,
  output logic                     STACK_EMPTY,
  output regfile_pkg::field5_t     MEMORY_OPTION,
  output logic                     MEMORY_OPTION_VALID,
  output regfile_pkg::field5_t     SPECIAL_CODE,
  output logic                     SPECIAL_VALID,
  output logic                     MEMORY_ADDRESS_LOAD
);
  import regfile_pkg::*;

  tos_if tos ();

  rsel_t   hold_select_code;
  field5_t store_code;
  field5_t option_field;
  logic    bus_store;
  logic    special_on;

  word_t   index_word;
  word_t   stack_upper_bound;
  word_t   code_segment_upper_bound;
  word_t   scratch_zero;
  word_t   scratch_one;
  word_t   code_segment_base;
  word_t   stack_lower_bound;
  word_t   hold_select_reg;
  word_t   next_hold_select;
  word_t   count_word;

  logic    store_tos;
  name_t   store_offset;

  // Microword field extraction
  assign hold_select_code    = MICRO_WORD[HOLD_SELECT_FIELD_LO:HOLD_SELECT_FIELD_HI];
  assign store_code   = MICRO_WORD[STORE_FIELD_LO:STORE_FIELD_HI];
  assign option_field = MICRO_WORD[SPECIAL_FIELD_LO:SPECIAL_FIELD_HI];

  // Shared bits mean either option or special, never both
  assign bus_store  = is_bus_store(store_code);
  assign special_on = !bus_store;

  assign MEMORY_OPTION       = bus_store ? option_field : field5_t'(0);
  assign MEMORY_OPTION_VALID = bus_store;
  assign SPECIAL_CODE        = special_on ? option_field : field5_t'(0);
  assign SPECIAL_VALID       = special_on;
  assign MEMORY_ADDRESS_LOAD = (store_code == ST_BUS_SP0);

  // Push and pop requests to the renamer
  assign tos.push = (store_code == ST_PUSH);
  assign tos.pop  = special_on && (option_field == SP_POP || option_field == SP_POP_SET_CC);

  // Store into the element registers
  always_comb begin
    store_tos    = 1'b1;
    store_offset = OFFS_FIRST;
    unique case (store_code)
      ST_FIRST:  store_offset = OFFS_FIRST;
      ST_SECOND: store_offset = OFFS_SECOND;
      ST_THIRD:  store_offset = OFFS_THIRD;
      ST_FOURTH: store_offset = OFFS_FOURTH;
      ST_BOTTOM: store_offset = OFFS_FIRST;
      // New top sits one name below the current one, or at the current name when a pop comes in the same cycle
      ST_PUSH:   store_offset = (tos.pop ? OFFS_FIRST : OFFS_FOURTH);
      default:   store_tos    = 1'b0;
    endcase
  end

  assign tos.wr_en     = store_tos;
  assign tos.wr_data   = RESULT_BUS;
  assign tos.wr_offset = store_offset;
  assign tos.sel_count = (store_code == ST_BOTTOM);

  // Read path through the mappers
  always_comb begin
    tos.rd_offset = OFFS_FIRST;
    tos.sel_sp1   = 1'b0;
    unique case (hold_select_code)
      RSEL_FIRST:      tos.rd_offset = OFFS_FIRST;
      RSEL_SECOND:     tos.rd_offset = OFFS_SECOND;
      RSEL_THIRD:      tos.rd_offset = OFFS_THIRD;
      RSEL_FOURTH:     tos.rd_offset = OFFS_FOURTH;
      RSEL_MEM_IN_TOS: tos.sel_sp1   = 1'b1;
      default:         tos.rd_offset = OFFS_FIRST;
    endcase
  end

  assign tos.sp1_low = scratch_one[SP1_NAME_LO:SP1_NAME_HI];

  tos_renamer u_renamer (
    .CLOCK (CLOCK),
    .RST   (RST),
    .tos   (tos)
  );

  tos_bank #(
    .DEPTH (TOS_DEPTH)
  ) u_bank (
    .CLOCK (CLOCK),
    .RST   (RST),
    .tos   (tos)
  );

  // Processor registers; no store code reaches operand, I/O or interrupt status
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      index_word <= WORD_ZERO;
    end else if (store_code == ST_INDEX) begin
      index_word <= RESULT_BUS;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      stack_upper_bound <= WORD_ZERO;
    end else if (store_code == ST_STACK_LIMIT) begin
      stack_upper_bound <= RESULT_BUS;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      code_segment_upper_bound <= WORD_ZERO;
    end else if (store_code == ST_CODE_LIMIT) begin
      code_segment_upper_bound <= RESULT_BUS;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      scratch_zero <= WORD_ZERO;
    end else if (store_code == ST_SCRATCH_ZER || store_code == ST_BUS_SP0) begin
      scratch_zero <= RESULT_BUS;
    end
  end

  // A store in the same cycle as a shift wins
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      scratch_one <= WORD_ZERO;
    end else if (store_code == ST_SCRATCH_ONE || store_code == ST_BUS_SP1) begin
      scratch_one <= RESULT_BUS;
    end else if (SCRATCH_ONE_SHIFT) begin
      scratch_one <= {scratch_one[1:WORD_W-1], SCRATCH_ONE_SERIAL_IN};
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      code_segment_base <= WORD_ZERO;
    end else if (store_code == ST_CODE_BASE) begin
      code_segment_base <= RESULT_BUS;
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      stack_lower_bound <= WORD_ZERO;
    end else if (store_code == ST_STACK_LOWER) begin
      stack_lower_bound <= RESULT_BUS;
    end
  end

  // Count sits in the most significant three bits as numbered
  always_comb begin
    count_word                   = WORD_ZERO;
    count_word[0:COUNT_FIELD_HI] = tos.count;
  end

  // R-bus source multiplexer
  always_comb begin
    next_hold_select = hold_select_reg;
    unique case (hold_select_code)
      RSEL_CODE_LIMIT:  next_hold_select = code_segment_upper_bound;
      RSEL_COUNT:       next_hold_select = count_word;
      RSEL_STACK_LIMIT: next_hold_select = stack_upper_bound;
      RSEL_MEM_IN_TOS:  next_hold_select = tos.rd_word;
      RSEL_PRE_ADDER:   next_hold_select = PRE_ADDER_WORD;
      RSEL_HOLD:        next_hold_select = hold_select_reg;
      RSEL_INDEX:       next_hold_select = index_word;
      RSEL_COND_INDEX:  next_hold_select = CURRENT_INSTRUCTION_REG[CIR_INDEX_BIT]
                                    ? index_word : WORD_ZERO;
      RSEL_FOURTH:      next_hold_select = tos.rd_word;
      RSEL_THIRD:       next_hold_select = tos.rd_word;
      RSEL_SECOND:      next_hold_select = tos.rd_word;
      RSEL_FIRST:       next_hold_select = tos.rd_word;
      RSEL_SCRATCH_ONE: next_hold_select = scratch_one;
      RSEL_SCRATCH_ZER: next_hold_select = scratch_zero;
      RSEL_RESULT_BUS:  next_hold_select = RESULT_BUS;
      RSEL_NOP:         next_hold_select = hold_select_reg;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      hold_select_reg <= WORD_ZERO;
    end else begin
      hold_select_reg <= next_hold_select;
    end
  end

  // Scratch one, the bases and the top-of-stack S copies leave on the S side
  assign R_BUS_REG              = hold_select_reg;
  assign SCRATCH_ONE_S          = scratch_one;
  assign SCRATCH_ONE_SERIAL_OUT = scratch_one[0];
  assign CODE_SEGMENT_BASE      = code_segment_base;
  assign STACK_LOWER_BOUND      = stack_lower_bound;
  assign TOS_S_COPIES           = tos.s_copies;
  assign STACK_ELEMENT_COUNT    = tos.count;
  assign STACK_EMPTY            = (tos.count == COUNT_RESET);
endmodule // hold_select_source_select
`default_nettype wire

//--- bench/hold_select_chk.sv
// Port-level assertions for the R-bus selector and renamer.
// Assumes it is bound onto hold_select_source_select and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module hold_select_chk (
  input wire logic                 CLOCK,
  input wire logic                 RST,
  input wire logic [0:31]          MICRO_WORD,
  input wire regfile_pkg::word_t   RESULT_BUS,
  input wire regfile_pkg::word_t   PRE_ADDER_WORD,
  input wire regfile_pkg::word_t   CURRENT_INSTRUCTION_REG,
  input wire logic                 SCRATCH_ONE_SHIFT,
  input wire logic                 SCRATCH_ONE_SERIAL_IN,
  input wire regfile_pkg::word_t   R_BUS_REG,
  input wire regfile_pkg::word_t   SCRATCH_ONE_S,
  input wire logic                 SCRATCH_ONE_SERIAL_OUT,
  input wire regfile_pkg::count_t  STACK_ELEMENT_COUNT,
  input wire logic                 STACK_EMPTY,
  input wire regfile_pkg::field5_t MEMORY_OPTION,
  input wire logic                 MEMORY_OPTION_VALID,
  input wire logic                 SPECIAL_VALID,
  input wire logic                 MEMORY_ADDRESS_LOAD
);
  import regfile_pkg::*;
  rsel_t   rs;
  field5_t st;
  field5_t spf;
  logic    bus_st;
  logic    push;
  logic    pop;
  assign rs = MICRO_WORD[28:31];
  assign st = MICRO_WORD[18:22];
  assign spf = MICRO_WORD[23:27];
  assign bus_st = (st == 5'h10) || (st == 5'h11) || (st == 5'h12);
  assign push = (st == 5'h0C);
  assign pop = !bus_st && ((spf == 5'h17) || (spf == 5'h16));

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_push;
    push && !pop && rs == 4'hF;
  endsequence
  sequence s_read_top;
    st == 5'h00 && !pop && rs == 4'hB;
  endsequence

  a_push_then_top: assert property (s_push ##1 s_read_top |=> R_BUS_REG == $past(RESULT_BUS, 2))
    else $error("pushed word not read back as top");
  a_count_read: assert property (rs == 4'h1 |=> R_BUS_REG[0:2] == $past(STACK_ELEMENT_COUNT)
    && R_BUS_REG[3:15] == 13'h0000)
    else $error("count read wrong");
  a_result_load: assert property (rs == 4'hE |=> R_BUS_REG == $past(RESULT_BUS))
    else $error("result bus not loaded");
  a_pre_adder: assert property (rs == 4'h4 |=> R_BUS_REG == $past(PRE_ADDER_WORD))
    else $error("pre-adder not loaded");
  a_hold_codes: assert property ((rs == 4'h5 || rs == 4'hF) |=> $stable(R_BUS_REG))
    else $error("R-bus register changed on hold");
  a_cond_zero: assert property (rs == 4'h7 && !CURRENT_INSTRUCTION_REG[4] |=> R_BUS_REG == 16'h0000)
    else $error("conditional index not zero");
  a_push_count: assert property (push && !pop |=> STACK_ELEMENT_COUNT == $past(STACK_ELEMENT_COUNT) + 3'h1)
    else $error("count not raised on push");
  a_pop_count: assert property (pop && !push |=> STACK_ELEMENT_COUNT == $past(STACK_ELEMENT_COUNT) - 3'h1)
    else $error("count not lowered on pop");
  a_empty_flag: assert property (STACK_EMPTY == (STACK_ELEMENT_COUNT == 3'h0))
    else $error("empty flag wrong");
  a_option_split: assert property (bus_st |-> MEMORY_OPTION_VALID && !SPECIAL_VALID
    && MEMORY_OPTION == spf)
    else $error("bus store decode wrong");
  a_addr_load: assert property (MEMORY_ADDRESS_LOAD == (st == 5'h11))
    else $error("address load wrong");
  a_scratch_shift: assert property (SCRATCH_ONE_SHIFT && st != 5'h05 && st != 5'h12
    |=> SCRATCH_ONE_S == {$past(SCRATCH_ONE_S[1:15]), $past(SCRATCH_ONE_SERIAL_IN)})
    else $error("scratch one shift wrong");
  a_serial_out: assert property (SCRATCH_ONE_SERIAL_OUT == SCRATCH_ONE_S[0])
    else $error("serial out not bit 0");
endmodule // hold_select_chk

bind hold_select_source_select hold_select_chk i_chk (
  .CLOCK(CLOCK), .RST(RST), .MICRO_WORD(MICRO_WORD), .RESULT_BUS(RESULT_BUS),
  .PRE_ADDER_WORD(PRE_ADDER_WORD), .CURRENT_INSTRUCTION_REG(CURRENT_INSTRUCTION_REG),
  .SCRATCH_ONE_SHIFT(SCRATCH_ONE_SHIFT), .SCRATCH_ONE_SERIAL_IN(SCRATCH_ONE_SERIAL_IN),
  .R_BUS_REG(R_BUS_REG), .SCRATCH_ONE_S(SCRATCH_ONE_S),
  .SCRATCH_ONE_SERIAL_OUT(SCRATCH_ONE_SERIAL_OUT), .STACK_ELEMENT_COUNT(STACK_ELEMENT_COUNT),
  .STACK_EMPTY(STACK_EMPTY), .MEMORY_OPTION(MEMORY_OPTION),
  .MEMORY_OPTION_VALID(MEMORY_OPTION_VALID), .SPECIAL_VALID(SPECIAL_VALID),
  .MEMORY_ADDRESS_LOAD(MEMORY_ADDRESS_LOAD)
);
`default_nettype wire

//--- bench/micro_seq_model.sv
// Microword sequencer model feeding the selector inputs.
// Assumes the bench calls put just after a rising CLOCK.
`timescale 1ns/1ps
`default_nettype none
module micro_seq_model (
  output logic [0:31]        micro_word,
  output regfile_pkg::word_t result_bus,
  output regfile_pkg::word_t pre_adder,
  output regfile_pkg::word_t current_instruction_reg,
  output logic               shift,
  output logic               serial_in
);
  import regfile_pkg::*;
  initial begin
    micro_word = 32'h0000_000F;
    result_bus = 16'h0000;
    pre_adder = 16'h0000;
    current_instruction_reg = 16'h0000;
    shift = 1'b0;
    serial_in = 1'b0;
  end
  // Stack reads are only issued once enough pushes have landed
  task automatic put(input field5_t st, input field5_t spf, input rsel_t rs, input word_t ub);
    micro_word = 32'h0000_0000;
    micro_word[18:22] = st;
    micro_word[23:27] = spf;
    micro_word[28:31] = rs;
    result_bus = ub;
  endtask
endmodule // micro_seq_model
`default_nettype wire

//--- bench/hold_select_source_select_tb.sv
// Self-checking bench for the R-bus selector and renamer.
// Assumes the sequencer model drives all microword-side inputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module hold_select_source_select_tb;
  import regfile_pkg::*;
  logic        CLOCK, RST, shift, serial_in, serial_out, empty, opt_valid, spec_valid, addr_load;
  logic [0:31] micro_word;
  logic [0:63] tos_s;
  word_t       result_bus, pre_adder, current_instruction_reg, r_bus, sp1_s, code_base, stack_lower;
  count_t      count;
  field5_t     opt, spec;
  field5_t     sts [5];
  rsel_t       rds [5];
  int          n_fail, checks_done, cycles;

  micro_seq_model i_seq (.micro_word(micro_word), .result_bus(result_bus), .pre_adder(pre_adder),
    .current_instruction_reg(current_instruction_reg), .shift(shift), .serial_in(serial_in));
  hold_select_source_select i_dut (.CLOCK(CLOCK), .RST(RST), .MICRO_WORD(micro_word),
    .RESULT_BUS(result_bus), .PRE_ADDER_WORD(pre_adder), .CURRENT_INSTRUCTION_REG(current_instruction_reg),
    .SCRATCH_ONE_SHIFT(shift), .SCRATCH_ONE_SERIAL_IN(serial_in), .R_BUS_REG(r_bus),
    .SCRATCH_ONE_S(sp1_s), .SCRATCH_ONE_SERIAL_OUT(serial_out), .CODE_SEGMENT_BASE(code_base),
    .STACK_LOWER_BOUND(stack_lower), .TOS_S_COPIES(tos_s), .STACK_ELEMENT_COUNT(count),
    .STACK_EMPTY(empty), .MEMORY_OPTION(opt), .MEMORY_OPTION_VALID(opt_valid),
    .SPECIAL_CODE(spec), .SPECIAL_VALID(spec_valid), .MEMORY_ADDRESS_LOAD(addr_load));

  initial begin
    CLOCK = 1'b0;
    forever #50 CLOCK = ~CLOCK;
  end

  task automatic step(input field5_t st, input field5_t spf, input rsel_t rs, input word_t ub);
    i_seq.put(st, spf, rs, ub);
    @(posedge CLOCK);
    #1;
  endtask

  task automatic rd(input rsel_t rs, input word_t exp);
    step(ST_NOP, 5'h00, rs, 16'h0000);
    `CHK("r_bus", exp, r_bus)
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard: whole sequence needs well under a hundred cycles
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    n_fail = 0;
    checks_done = 0;
    cycles = 0;
    RST = 1'b1;
    sts = '{ST_INDEX, ST_STACK_LIMIT, ST_CODE_LIMIT, ST_SCRATCH_ZER, ST_SCRATCH_ONE};
    rds = '{RSEL_INDEX, RSEL_STACK_LIMIT, RSEL_CODE_LIMIT, RSEL_SCRATCH_ZER, RSEL_SCRATCH_ONE};
    repeat (6) @(posedge CLOCK);
    #1;
    `CHK("reset r_bus", 16'h0000, r_bus)
    `CHK("reset count", 3'h0, count)
    `CHK("reset tos", 64'h0000_0000_0000_0000, tos_s)
    RST = 1'b0;
    // Write all first so the reads also prove the registers hold
    for (int i = 0; i < 5; i++) step(sts[i], 5'h00, RSEL_NOP, word_t'(16'h1111 * (i + 1)));
    for (int i = 0; i < 5; i++) rd(rds[i], word_t'(16'h1111 * (i + 1)));
    `CHK("scratch one s", 16'h5555, sp1_s)
    step(ST_CODE_BASE, 5'h00, RSEL_NOP, 16'hA5A5);
    step(ST_STACK_LOWER, 5'h00, RSEL_NOP, 16'h5A5A);
    `CHK("code base", 16'hA5A5, code_base)
    `CHK("stack lower", 16'h5A5A, stack_lower)
    rd(RSEL_COND_INDEX, 16'h0000);
    i_seq.current_instruction_reg = 16'h0800;
    rd(RSEL_COND_INDEX, 16'h1111);
    step(ST_NOP, 5'h00, RSEL_RESULT_BUS, 16'hBEEF);
    `CHK("result bus", 16'hBEEF, r_bus)
    i_seq.pre_adder = 16'h1234;
    rd(RSEL_PRE_ADDER, 16'h1234);
    step(ST_NOP, 5'h00, RSEL_HOLD, 16'hFFFF);
    step(ST_NOP, 5'h00, RSEL_NOP, 16'hFFFF);
    `CHK("hold", 16'h1234, r_bus)
    for (int i = 0; i < 4; i++) begin
      step(ST_PUSH, 5'h00, RSEL_NOP, word_t'(16'hC000 + i));
      `CHK("push count", count_t'(i + 1), count)
    end
    rd(RSEL_FIRST, 16'hC003);
    rd(RSEL_SECOND, 16'hC002);
    rd(RSEL_THIRD, 16'hC001);
    rd(RSEL_FOURTH, 16'hC000);
    rd(RSEL_COUNT, 16'h8000);
    `CHK("s copies", {16'hC003, 16'hC002, 16'hC001, 16'hC000}, tos_s)
    rd(RSEL_MEM_IN_TOS, 16'hC002);
    step(ST_BOTTOM, 5'h00, RSEL_NOP, 16'hD00D);
    rd(RSEL_FOURTH, 16'hD00D);
    step(ST_SECOND, 5'h00, RSEL_NOP, 16'hB00B);
    `CHK("s copy one", 16'hB00B, tos_s[16:31])
    step(ST_NOP, SP_POP, RSEL_NOP, 16'h0000);
    step(ST_NOP, SP_POP_SET_CC, RSEL_NOP, 16'h0000);
    `CHK("pop count", 3'h2, count)
    rd(RSEL_FIRST, 16'hC001);
    step(ST_NOP, SP_POP, RSEL_NOP, 16'h0000);
    step(ST_NOP, SP_POP, RSEL_NOP, 16'h0000);
    `CHK("empty", 1'b1, empty)
    i_seq.put(ST_BUS_SP0, SP_POP, RSEL_NOP, 16'h7E7E);
    #1;
    `CHK("option", 6'h37, {opt_valid, opt})
    `CHK("special valid", 1'b0, spec_valid)
    `CHK("address load", 1'b1, addr_load)
    @(posedge CLOCK);
    #1;
    `CHK("no pop on bus store", 3'h0, count)
    rd(RSEL_SCRATCH_ZER, 16'h7E7E);
    i_seq.put(ST_NOP, 5'h05, RSEL_NOP, 16'h0000);
    #1;
    `CHK("special", 7'h45, {spec_valid, opt_valid, spec})
    @(posedge CLOCK);
    #1;
    step(ST_SCRATCH_ONE, 5'h00, RSEL_NOP, 16'h8001);
    `CHK("serial out", 1'b1, serial_out)
    i_seq.shift = 1'b1;
    i_seq.serial_in = 1'b1;
    step(ST_NOP, 5'h00, RSEL_NOP, 16'h0000);
    `CHK("shifted", 16'h0003, sp1_s)
    step(ST_BUS_SP1, 5'h00, RSEL_NOP, 16'h4444);
    `CHK("store over shift", 16'h4444, sp1_s)
    i_seq.shift = 1'b0;
    report_and_stop();
  end
endmodule // hold_select_source_select_tb
`default_nettype wire
